// ===== sqlr_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module sqlr_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset_n,
    input  wire logic               i_flush,
    // Fill side
    input  wire logic               i_in_valid,
    output logic                    o_in_ready,
    input  wire logic [WIDTH-1:0]   i_in_data,
    // Drain side
    output logic                    o_out_valid,
    input  wire logic               i_out_ready,
    output logic [WIDTH-1:0]        o_out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0]  o_count
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("sqlr_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } sqlr_fifo_s;

    sqlr_fifo_s             st_q;
    sqlr_fifo_s             st_d;
    logic [WIDTH-1:0]       mem_q [DEPTH];
    logic                   push;
    logic                   pop;

    // Handshakes and outputs
    assign o_in_ready  = (st_q.count != (AW+1)'(DEPTH));
    assign o_out_valid = (st_q.count != '0);
    assign o_out_data  = mem_q[st_q.rd_ptr];
    assign o_count     = st_q.count;
    assign push        = i_in_valid & o_in_ready & ~i_flush;
    assign pop         = o_out_valid & i_out_ready & ~i_flush;

    // Pointer and count update
    always_comb begin
        st_d = st_q;
        if (i_flush) begin
            st_d = '0;
        end else begin
            if (push) begin
                st_d.wr_ptr = st_q.wr_ptr + AW'(1);
            end
            if (pop) begin
                st_d.rd_ptr = st_q.rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                st_d.count = st_q.count + (AW+1)'(1);
            end else if (pop && !push) begin
                st_d.count = st_q.count - (AW+1)'(1);
            end
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[st_q.wr_ptr] <= i_in_data;
        end
    end
endmodule : sqlr_fifo

// ===== sqlr_host.sv
// Host model reaching the queue registers through one-cycle strobes
`timescale 1ns/1ps
module sqlr_host (
    input  wire logic        i_clk_sys,
    input  wire logic [23:0] i_rdata,
    input  wire logic        i_rvalid,
    output logic             o_wr,
    output logic             o_rd,
    output logic [5:0]       o_addr,
    output logic [23:0]      o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    // Write pulse; released data is inverted so no stale value lingers
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(negedge i_clk_sys);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    // Read pulse; answer taken in the cycle that carries rvalid
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(negedge i_clk_sys);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk_sys);
        o_rd = 1'b0;
        d = i_rvalid ? i_rdata : 'x;
    endtask
endmodule // sqlr_host

// ===== sqlr_pkg.sv
// Package of constants for the sample queue limit and readout block
package sqlr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [5:0]  ADDR_LIMITS    = 6'h3C;
    localparam logic [5:0]  ADDR_READOUT   = 6'h3D;
    localparam logic [23:0] LIMITS_RESET   = 24'hFFF000;
    localparam logic [23:0] READOUT_RESET  = 24'h000000;
    // ****************************************
    // Field layout
    // ****************************************
    localparam int          UPPER_LSB      = 12;
    localparam int          LIMIT_W        = 12;
    localparam int          DATA_W         = 24;
    localparam int          CHAN_W         = 4;
    localparam int          DEPTH_DEF      = 16;
endpackage : sqlr_pkg

// ===== sqlr_properties.sv
// Concurrent checks on the sample queue status, limit and readout ports
`timescale 1ns/1ps
module sqlr_properties
    import sqlr_pkg::*;
#(parameter int DEPTH = 16, parameter int N_CHAN = 16) (
    input wire logic i_clk_sys, i_reset_n, i_queue_enable, i_queue_clear,
    input wire logic [N_CHAN-1:0] i_channel_limit_check_enable,
    input wire logic i_result_valid, o_result_ready, i_reg_rd, o_reg_rvalid,
    input wire logic [DATA_W-1:0] i_result_data,
    input wire logic [CHAN_W-1:0] i_result_chan,
    input wire logic o_empty_flag, o_irq_empty, o_irq_above, o_irq_below,
    input wire logic o_above_limit_indicator, o_below_limit_indicator,
    input wire logic [LIMIT_W-1:0] o_upper_limit_field, o_lower_limit_field
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    logic push, cmp_en;
    // Accepted result and its channel compare enable
    assign push = i_result_valid && o_result_ready && i_queue_enable && !i_queue_clear;
    assign cmp_en = push && i_channel_limit_check_enable[i_result_chan];
    a_empty_irq_same: assert property (o_irq_empty == o_empty_flag)
        else $error("empty interrupt differs from flag");
    a_disable_empty: assert property (!i_queue_enable |=> o_empty_flag)
        else $error("empty low after disable");
    a_clear_empty: assert property (i_queue_clear |=> o_empty_flag)
        else $error("empty low after clear");
    a_push_nonempty: assert property (push |=> !o_empty_flag)
        else $error("empty high after push");
    a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_no_spurious: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read answer without read");
    a_clear_flags: assert property (i_queue_clear |=> !o_above_limit_indicator
        && !o_below_limit_indicator) else $error("limit flag kept");
    a_limit_reset: assert property ($rose(i_reset_n) |->
        {o_upper_limit_field, o_lower_limit_field} == LIMITS_RESET) else $error("limit reset");
    a_above_set: assert property (cmp_en && i_result_data[23:12] >=
        o_upper_limit_field |=> o_above_limit_indicator) else $error("above flag missed");
    a_below_set: assert property (cmp_en && i_result_data[23:12] <=
        o_lower_limit_field |=> o_below_limit_indicator) else $error("below flag missed");
    a_irq_follow: assert property ({o_irq_above, o_irq_below} ==
        {o_above_limit_indicator, o_below_limit_indicator}) else $error("limit irq differs");
endmodule // sqlr_properties
bind sqlr_top sqlr_properties #(.DEPTH(DEPTH), .N_CHAN(N_CHAN)) u_props (.*);

// ===== sqlr_top.sv
// Sample queue status, limit compare and readout register
`timescale 1ns/1ps
module sqlr_top
    import sqlr_pkg::*;
#(
    parameter int DEPTH    = DEPTH_DEF,
    parameter int N_CHAN   = 16
) (
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset_n,
    // Queue controls from the rest of the unit
    input  wire logic                    i_queue_enable,
    input  wire logic                    i_queue_clear,
    input  wire logic [N_CHAN-1:0]       i_channel_limit_check_enable,
    input  wire logic [$clog2(DEPTH):0]  i_watermark,
    // Conversion results into the queue
    input  wire logic                    i_result_valid,
    output logic                         o_result_ready,
    input  wire logic [DATA_W-1:0]       i_result_data,
    input  wire logic [CHAN_W-1:0]       i_result_chan,
    // Register access from the serial interface
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    input  wire logic [5:0]              i_reg_addr,
    input  wire logic [DATA_W-1:0]       i_reg_wdata,
    output logic [DATA_W-1:0]            o_reg_rdata,
    output logic                         o_reg_rvalid,
    // Status flags and interrupts
    output logic                         o_empty_flag,
    output logic                         o_watermark_flag,
    output logic                         o_above_limit_indicator,
    output logic                         o_below_limit_indicator,
    output logic                         o_irq_empty,
    output logic                         o_irq_watermark,
    output logic                         o_irq_above,
    output logic                         o_irq_below,
    // Current limits
    output logic [LIMIT_W-1:0]           o_upper_limit_field,
    output logic [LIMIT_W-1:0]           o_lower_limit_field
);
    localparam int CW = $clog2(DEPTH);
    localparam int FW = DATA_W + CHAN_W;

    initial begin
        if (N_CHAN > (1 << CHAN_W) || N_CHAN < 1) begin
            $error("sqlr_top: N_CHAN out of range for the channel tag width");
        end
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0] limits;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              above;
        logic              below;
    } sqlr_state_s;

    sqlr_state_s         st_q;
    sqlr_state_s         st_d;
    logic                q_out_valid;
    logic [FW-1:0]       q_out_data;
    logic [CW:0]         q_count;
    logic                q_push;
    logic                q_pop;
    logic                flush;
    logic                rd_readout;
    logic [LIMIT_W-1:0]  cmp_val;
    logic                cmp_en;
    logic                empty_now;

    // ****************************************
    // Result queue
    // ****************************************
    // Disabled queue drops its contents and discards any result offered while o_result_ready stays high
    assign flush      = i_queue_clear | ~i_queue_enable;
    assign rd_readout = i_reg_rd && (i_reg_addr == ADDR_READOUT);
    assign q_pop      = rd_readout & q_out_valid;
    assign q_push     = i_result_valid & o_result_ready & ~flush;

    sqlr_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_reset_n   (i_reset_n),
        .i_flush     (flush),
        .i_in_valid  (i_result_valid & i_queue_enable),
        .o_in_ready  (o_result_ready),
        .i_in_data   ({i_result_chan, i_result_data}),
        .o_out_valid (q_out_valid),
        .i_out_ready (rd_readout),
        .o_out_data  (q_out_data),
        .o_count     (q_count)
    );

    // ****************************************
    // Limit compare on stored results
    // ****************************************
    // Unsigned compare of the top twelve bits of the incoming result
    assign cmp_val = i_result_data[DATA_W-1 -: LIMIT_W];
    assign cmp_en  = q_push && (int'(i_result_chan) < N_CHAN)
                     && i_channel_limit_check_enable[i_result_chan];

    // Queue is empty next cycle when cleared, disabled or last entry popped
    assign empty_now = flush || (q_count == (CW+1)'(1) && q_pop && !q_push)
                       || (q_count == '0 && !q_push);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;
        // Limit register write
        if (i_reg_wr && i_reg_addr == ADDR_LIMITS) begin
            st_d.limits = i_reg_wdata;
        end
        // Register read data
        if (i_reg_rd) begin
            st_d.rvalid = 1'b1;
            if (i_reg_addr == ADDR_LIMITS) begin
                st_d.rdata = st_q.limits;
            end else if (rd_readout) begin
                st_d.rdata = q_out_valid ? q_out_data[DATA_W-1:0] : READOUT_RESET;
            end else begin
                st_d.rdata = '0;
            end
        end
        // Threshold flags: set on compare, cleared when queue empties
        if (empty_now) begin
            st_d.above = 1'b0;
            st_d.below = 1'b0;
        end else begin
            if (cmp_en && cmp_val >= st_q.limits[DATA_W-1:UPPER_LSB]) begin
                st_d.above = 1'b1;
            end
            if (cmp_en && cmp_val <= st_q.limits[LIMIT_W-1:0]) begin
                st_d.below = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            st_q        <= '0;
            st_q.limits <= LIMITS_RESET;
            st_q.rdata  <= READOUT_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Empty follows occupancy; disabled or reset queue holds zero entries
    assign o_empty_flag            = (q_count == '0);
    assign o_irq_empty             = o_empty_flag;
    assign o_watermark_flag        = (q_count >= i_watermark) && (i_watermark != '0);
    assign o_irq_watermark         = o_watermark_flag;
    assign o_above_limit_indicator = st_q.above;
    assign o_below_limit_indicator = st_q.below;
    assign o_irq_above             = st_q.above;
    assign o_irq_below             = st_q.below;
    assign o_reg_rdata             = st_q.rdata;
    assign o_reg_rvalid            = st_q.rvalid;
    assign o_upper_limit_field     = st_q.limits[DATA_W-1:UPPER_LSB];
    assign o_lower_limit_field     = st_q.limits[LIMIT_W-1:0];
endmodule : sqlr_top

// ===== sqlr_top_tb.sv
// Self-checking bench for the sample queue limit and readout block
`timescale 1ns/1ps
module sqlr_top_tb;
    import sqlr_pkg::*;
    logic i_clk_sys = 0, i_reset_n = 0, en = 0, clr = 0, vld = 0, eh, el;
    logic [15:0] ce = '0;
    logic [4:0] wm = '0;
    logic [3:0] ch = '0;
    logic [11:0] up, lw;
    logic [23:0] dat = '0, rdd, q[$];
    int err_total = 0, checks = 0, n;
    wire logic wr, rd, rdy, rv, emp, wmf, hi, lo, wmi;
    wire logic [5:0] adr;
    wire logic [23:0] wd, rdat;
    wire logic [11:0] upf, lwf;
    initial forever #4 i_clk_sys = ~i_clk_sys;
    sqlr_host host (.i_clk_sys(i_clk_sys), .i_rdata(rdat), .i_rvalid(rv), .o_wr(wr),
        .o_rd(rd), .o_addr(adr), .o_wdata(wd));
    sqlr_top #(.DEPTH(16), .N_CHAN(16)) dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_queue_enable(en), .i_queue_clear(clr), .i_channel_limit_check_enable(ce),
        .i_watermark(wm), .i_result_valid(vld), .o_result_ready(rdy), .i_result_data(dat),
        .i_result_chan(ch), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(adr), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_empty_flag(emp), .o_watermark_flag(wmf),
        .o_above_limit_indicator(hi), .o_below_limit_indicator(lo), .o_irq_empty(),
        .o_irq_watermark(wmi), .o_irq_above(), .o_irq_below(), .o_upper_limit_field(upf),
        .o_lower_limit_field(lwf));
    // Compare one value and count the outcome
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Offer one result; model takes it only when ready
    task automatic push(input logic [23:0] d, input logic [3:0] c);
        @(negedge i_clk_sys);
        {vld, dat, ch} = {1'b1, d, c};
        chk(rdy, q.size() < 16);
        if (rdy) begin
            q.push_back(d);
            eh |= ce[c] && d[23:12] >= up;
            el |= ce[c] && d[23:12] <= lw;
        end
        @(negedge i_clk_sys);
        {vld, dat} = {1'b0, ~d};
    endtask
    // One-cycle queue clear
    task automatic flush;
        @(negedge i_clk_sys) clr = 1;
        @(negedge i_clk_sys) clr = 0;
        {eh, el} = 0;
        q.delete();
    endtask
    initial begin
        #200000 err_total++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hd445a942));
        repeat (16) @(negedge i_clk_sys);
        i_reset_n = 1;
        chk(emp, 1);
        host.rd(ADDR_LIMITS, rdd);
        chk(rdd, LIMITS_RESET);
        chk({upf, lwf}, LIMITS_RESET);
        host.rd(ADDR_READOUT, rdd);
        chk(rdd, 0);
        host.rd(6'h3E, rdd);
        chk(rdd, 0);
        en = 1;
        @(negedge i_clk_sys);
        chk(emp, 1);
        $display("reset test done");
        for (int t = 0; t < 4; t++) begin
            {up, lw} = t == 0 ? 24'h800_7FF : $urandom;
            host.wr(ADDR_LIMITS, {up, lw});
            host.wr(ADDR_READOUT, $urandom);
            host.rd(ADDR_LIMITS, rdd);
            chk(rdd, {up, lw});
            chk({upf, lwf}, {up, lw});
            flush();
            chk(emp, 1);
            chk({hi, lo}, 0);
            {ce, wm} = {16'($urandom), 5'($urandom_range(1, 16))};
            n = t == 3 ? 17 : $urandom_range(1, 16);
            repeat (n) begin
                dat = $urandom;
                case ($urandom_range(0, 2))
                    0: dat[23:12] = up;
                    1: dat[23:12] = lw;
                    default: ;
                endcase
                push(dat, $urandom);
                chk(emp, 0);
                chk(wmf, q.size() >= wm);
                chk(wmi, q.size() >= wm);
                chk({hi, lo}, {eh, el});
            end
            while (q.size() > 0) begin
                host.rd(ADDR_READOUT, rdd);
                chk(rdd, q.pop_front());
                chk(emp, q.size() == 0);
            end
            chk({hi, lo}, 0);
            $display("limit round %0d done", t);
        end
        push($urandom, $urandom);
        en = 0;
        @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(emp, 1);
        $display("disable test done");
        give_verdict();
    end
endmodule // sqlr_top_tb
